// ===== inc/asp_pkg.sv
package asp_pkg;
  localparam int NUM_PORTS = 3;
  localparam int DIV_W = 16;
  localparam int FRAC_W = 6;
  localparam logic [3:0] OSR_NORMAL_M1 = 4'hF;
  localparam logic [3:0] OSR_FAST_M1 = 4'h7;
  localparam int TX_W = 8;
  localparam int TX_DEPTH = 64;
  localparam int RX_W = 12;
  localparam int RX_DEPTH = 64;
  localparam int RX_FRM_BIT = 8;
  localparam int RX_PAR_BIT = 9;
  localparam int RX_BRK_BIT = 10;
  localparam int RX_OVR_BIT = 11;
  localparam logic [1:0] PAR_EVEN = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_STICK0 = 2'h2;
  localparam logic [1:0] PAR_STICK1 = 2'h3;
  localparam logic [2:0] MIN_DATA_BITS = 3'h5;
  localparam logic [DIV_W-1:0] DIV_RESET = 16'h0001;
  localparam logic [FRAC_W-1:0] FRAC_RESET = 6'h00;
  localparam logic LINE_IDLE = 1'b1;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} asp_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_BREAK} asp_rx_e;
endpackage

// ===== core/asp_top.sv
`timescale 1ns/1ns

module asp_fifo #(
  parameter int W = 8,
  parameter int D = 64
) (
  input wire logic clock, // System clock
  input wire logic rstn, // Sync reset, active low
  input wire logic one_deep, // Limit to one entry
  input wire logic in_valid, // Write request
  output logic in_ready, // Room available
  input wire logic [W-1:0] in_data, // Write data
  output logic out_valid, // Data available
  input wire logic out_ready, // Read accept
  output logic [W-1:0] out_data, // Head entry
  output logic [$clog2(D):0] count // Entries held
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic push;
  logic pop;

  assign in_ready = one_deep ? (count == '0) : (count != (AW+1)'(D));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // asp_fifo

module asp_port #(
  parameter bit HAS_MODEM = 1'b0
) (
  input wire logic clock, // Serial reference clock
  input wire logic rstn, // Sync reset, active low
  input wire logic [asp_pkg::DIV_W-1:0] baud_int, // Integer divisor
  input wire logic [asp_pkg::FRAC_W-1:0] baud_frac, // Fraction in 64ths
  input wire logic fast_mode, // 8x oversampling
  input wire logic [1:0] data_bits, // Data bits minus five
  input wire logic parity_en, // Parity bit present
  input wire logic [1:0] parity_mode, // Even, odd, stick0, stick1
  input wire logic stop2, // Two stop bits
  input wire logic fifo_en, // FIFOs enabled
  input wire logic send_break, // Hold line low
  input wire logic cts_flow_en, // Gate transmit on CTS
  input wire logic sw_flow_en, // In-band flow control
  input wire logic [7:0] xoff_char, // Pause character
  input wire logic [7:0] xon_char, // Resume character
  input wire logic dtr_req, // Terminal ready request
  input wire logic [7:0] tx_data, // Byte to send
  input wire logic tx_valid, // Byte offered
  output logic tx_ready, // Byte accepted
  output logic [asp_pkg::RX_W-1:0] rx_data, // Byte and flags
  output logic rx_valid, // Entry available
  input wire logic rx_ready, // Entry consumed
  input wire logic serial_rx_pin, // Receive line
  output logic serial_tx_pin, // Transmit line
  input wire logic cts_n_pin, // Clear to send, low active
  output logic rts_n_pin, // Request to send, low active
  input wire logic dcd_n_pin, // Carrier detect, low active
  input wire logic dsr_n_pin, // Data set ready, low active
  input wire logic ri_n_pin, // Ring indicator, low active
  output logic dtr_n_pin, // Terminal ready, low active
  output logic [3:0] modem_status, // CTS, DCD, DSR, RI levels
  output logic tx_paused // Stopped by pause character
);
  logic [asp_pkg::DIV_W-1:0] div_cnt_reg;
  logic [asp_pkg::FRAC_W:0] frac_acc_reg;
  logic os_tick;
  logic [3:0] osr_m1;
  logic [2:0] nbits_m1;
  logic [1:0] rx_sync_reg;
  logic [1:0] cts_sync_reg;
  logic [1:0] dcd_sync_reg;
  logic [1:0] dsr_sync_reg;
  logic [1:0] ri_sync_reg;
  logic rx_s;
  logic cts_ok;
  asp_pkg::asp_tx_e tx_st;
  logic [3:0] tx_cnt;
  logic [2:0] tx_idx;
  logic [7:0] tx_sh;
  logic tx_par;
  logic tx_line;
  logic txf_valid;
  logic [7:0] txf_data;
  logic tx_pop;
  logic [$clog2(asp_pkg::TX_DEPTH):0] txf_count;
  asp_pkg::asp_rx_e rx_st;
  logic [3:0] rx_cnt;
  logic [2:0] rx_idx;
  logic [7:0] rx_sh;
  logic rx_par_err;
  logic [7:0] rx_byte;
  logic rx_frame_done;
  logic rx_stop_low;
  logic rx_is_break;
  logic rx_ctl_char;
  logic rx_push;
  logic rxf_ready;
  logic ovr_reg;
  logic [asp_pkg::RX_W-1:0] rx_word;
  logic [$clog2(asp_pkg::RX_DEPTH):0] rxf_count;

  assign osr_m1 = fast_mode ? asp_pkg::OSR_FAST_M1 : asp_pkg::OSR_NORMAL_M1;
  assign nbits_m1 = 3'(asp_pkg::MIN_DATA_BITS - 3'h1) + {1'b0, data_bits};

  // Fractional divider: carry from the fraction stretches one period by a cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      div_cnt_reg <= asp_pkg::DIV_RESET;
      frac_acc_reg <= '0;
      os_tick <= 1'b0;
    end else begin
      os_tick <= 1'b0;
      if (div_cnt_reg <= 16'h0001) begin
        frac_acc_reg <= {1'b0, frac_acc_reg[asp_pkg::FRAC_W-1:0]} + {1'b0, baud_frac};
        div_cnt_reg <= (baud_int == '0 ? asp_pkg::DIV_RESET : baud_int)
                     + {15'h0000, frac_acc_reg[asp_pkg::FRAC_W]};
        os_tick <= 1'b1;
      end else begin
        div_cnt_reg <= div_cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rx_sync_reg <= {2{asp_pkg::LINE_IDLE}};
      cts_sync_reg <= 2'h3;
      dcd_sync_reg <= 2'h3;
      dsr_sync_reg <= 2'h3;
      ri_sync_reg <= 2'h3;
    end else begin
      rx_sync_reg <= {rx_sync_reg[0], serial_rx_pin};
      cts_sync_reg <= {cts_sync_reg[0], cts_n_pin};
      dcd_sync_reg <= {dcd_sync_reg[0], HAS_MODEM ? dcd_n_pin : 1'b1};
      dsr_sync_reg <= {dsr_sync_reg[0], HAS_MODEM ? dsr_n_pin : 1'b1};
      ri_sync_reg <= {ri_sync_reg[0], HAS_MODEM ? ri_n_pin : 1'b1};
    end
  end
  assign rx_s = rx_sync_reg[1];
  assign cts_ok = !cts_flow_en || !cts_sync_reg[1];

  // Plain levels only; no change history is kept
  always_ff @(posedge clock) begin
    if (!rstn) begin
      modem_status <= 4'h0;
      dtr_n_pin <= 1'b1;
      rts_n_pin <= 1'b1;
    end else begin
      modem_status <= ~{cts_sync_reg[1], dcd_sync_reg[1], dsr_sync_reg[1], ri_sync_reg[1]};
      dtr_n_pin <= !(HAS_MODEM && dtr_req);
      rts_n_pin <= !rxf_ready;
    end
  end

  asp_fifo #(.W(asp_pkg::TX_W), .D(asp_pkg::TX_DEPTH)) u_txf (
    .clock(clock), .rstn(rstn), .one_deep(!fifo_en),
    .in_valid(tx_valid), .in_ready(tx_ready), .in_data(tx_data),
    .out_valid(txf_valid), .out_ready(tx_pop), .out_data(txf_data),
    .count(txf_count)
  );

  assign tx_pop = (tx_st == asp_pkg::TX_IDLE) && os_tick && txf_valid && !tx_paused && cts_ok;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      tx_st <= asp_pkg::TX_IDLE;
      tx_cnt <= 4'h0;
      tx_idx <= 3'h0;
      tx_sh <= 8'h00;
      tx_par <= 1'b0;
    end else if (tx_pop) begin
      tx_st <= asp_pkg::TX_START;
      tx_cnt <= 4'h0;
      tx_sh <= txf_data;
      case (parity_mode)
        asp_pkg::PAR_EVEN: tx_par <= ^(txf_data & ~(8'hFF << ({1'b0, nbits_m1} + 4'h1)));
        asp_pkg::PAR_ODD: tx_par <= ~^(txf_data & ~(8'hFF << ({1'b0, nbits_m1} + 4'h1)));
        asp_pkg::PAR_STICK0: tx_par <= 1'b0;
        default: tx_par <= 1'b1;
      endcase
    end else if (os_tick && tx_st != asp_pkg::TX_IDLE) begin
      tx_cnt <= (tx_cnt == osr_m1) ? 4'h0 : tx_cnt + 4'h1;
      if (tx_cnt == osr_m1) begin
        case (tx_st)
          asp_pkg::TX_START: begin
            tx_st <= asp_pkg::TX_DATA;
            tx_idx <= 3'h0;
          end
          asp_pkg::TX_DATA: begin
            tx_sh <= {1'b0, tx_sh[7:1]};
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx == nbits_m1) begin
              tx_st <= parity_en ? asp_pkg::TX_PARITY : asp_pkg::TX_STOP;
              tx_idx <= 3'h0;
            end
          end
          asp_pkg::TX_PARITY: tx_st <= asp_pkg::TX_STOP;
          asp_pkg::TX_STOP: begin
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx[0] == stop2) begin
              tx_st <= asp_pkg::TX_IDLE;
            end
          end
          default: tx_st <= asp_pkg::TX_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    case (tx_st)
      asp_pkg::TX_START: tx_line = 1'b0;
      asp_pkg::TX_DATA: tx_line = tx_sh[0];
      asp_pkg::TX_PARITY: tx_line = tx_par;
      default: tx_line = asp_pkg::LINE_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      serial_tx_pin <= asp_pkg::LINE_IDLE;
    end else begin
      serial_tx_pin <= send_break ? 1'b0 : tx_line;
    end
  end

  assign rx_byte = rx_sh >> (3'h7 - nbits_m1);
  assign rx_frame_done = (rx_st == asp_pkg::RX_STOP) && os_tick && (rx_cnt == osr_m1);
  assign rx_stop_low = rx_frame_done && !rx_s;
  assign rx_is_break = rx_stop_low && (rx_byte == 8'h00) && !rx_par_err;
  assign rx_ctl_char = sw_flow_en && !rx_stop_low && !rx_par_err
                    && (rx_byte == xoff_char || rx_byte == xon_char);
  assign rx_push = rx_frame_done && !rx_ctl_char;
  assign rx_word = {ovr_reg || (rx_push && !rxf_ready), rx_is_break, rx_par_err, rx_stop_low,
                    rx_byte};

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rx_st <= asp_pkg::RX_IDLE;
      rx_cnt <= 4'h0;
      rx_idx <= 3'h0;
      rx_sh <= 8'h00;
      rx_par_err <= 1'b0;
    end else if (os_tick) begin
      rx_cnt <= (rx_cnt == osr_m1) ? 4'h0 : rx_cnt + 4'h1;
      case (rx_st)
        asp_pkg::RX_IDLE: begin
          rx_cnt <= 4'h0;
          rx_par_err <= 1'b0;
          if (!rx_s) begin
            rx_st <= asp_pkg::RX_START;
          end
        end
        asp_pkg::RX_START: begin
          if (rx_cnt == (osr_m1 >> 1)) begin
            rx_cnt <= 4'h0;
            rx_idx <= 3'h0;
            rx_st <= rx_s ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
          end
        end
        asp_pkg::RX_DATA: begin
          if (rx_cnt == osr_m1) begin
            rx_sh <= {rx_s, rx_sh[7:1]};
            rx_idx <= rx_idx + 3'h1;
            if (rx_idx == nbits_m1) begin
              rx_st <= parity_en ? asp_pkg::RX_PARITY : asp_pkg::RX_STOP;
            end
          end
        end
        asp_pkg::RX_PARITY: begin
          if (rx_cnt == osr_m1) begin
            rx_st <= asp_pkg::RX_STOP;
            case (parity_mode)
              asp_pkg::PAR_EVEN: rx_par_err <= (^rx_byte) != rx_s;
              asp_pkg::PAR_ODD: rx_par_err <= (~^rx_byte) != rx_s;
              asp_pkg::PAR_STICK0: rx_par_err <= rx_s;
              default: rx_par_err <= !rx_s;
            endcase
          end
        end
        asp_pkg::RX_STOP: begin
          if (rx_cnt == osr_m1) begin
            rx_st <= rx_is_break ? asp_pkg::RX_BREAK : asp_pkg::RX_IDLE;
          end
        end
        asp_pkg::RX_BREAK: begin
          if (rx_s) begin
            rx_st <= asp_pkg::RX_IDLE;
          end
        end
        default: rx_st <= asp_pkg::RX_IDLE;
      endcase
    end
  end

  // Overrun rides on the next stored entry; a new loss wins over the clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ovr_reg <= 1'b0;
    end else if (rx_push && !rxf_ready) begin
      ovr_reg <= 1'b1;
    end else if (rx_push) begin
      ovr_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn || !sw_flow_en) begin
      tx_paused <= 1'b0;
    end else if (rx_frame_done && rx_ctl_char) begin
      tx_paused <= (rx_byte == xoff_char);
    end
  end

  asp_fifo #(.W(asp_pkg::RX_W), .D(asp_pkg::RX_DEPTH)) u_rxf (
    .clock(clock), .rstn(rstn), .one_deep(!fifo_en),
    .in_valid(rx_push), .in_ready(rxf_ready), .in_data(rx_word),
    .out_valid(rx_valid), .out_ready(rx_ready), .out_data(rx_data),
    .count(rxf_count)
  );

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  a_break_line_low: assert property (send_break |=> !serial_tx_pin)
    else $error("break not driven");
  a_idle_line_high: assert property ((tx_st == asp_pkg::TX_IDLE && !send_break) |=> serial_tx_pin)
    else $error("idle line not high");
  a_stop_line_high: assert property ((tx_st == asp_pkg::TX_STOP && !send_break) |=> serial_tx_pin)
    else $error("stop bit not high");
  a_tx_one_deep: assert property (!fifo_en && $past(!fifo_en, 1) |-> txf_count <= 1)
    else $error("holding register overfilled");
  a_rx_depth_cap: assert property (rxf_count <= asp_pkg::RX_DEPTH)
    else $error("receive fifo beyond depth");
  a_false_start: assert property ((rx_st == asp_pkg::RX_START && os_tick
      && rx_cnt == (osr_m1 >> 1) && rx_s) |=> rx_st == asp_pkg::RX_IDLE)
    else $error("false start accepted");
  a_cts_blocks_tx: assert property ((cts_flow_en && cts_sync_reg[1]
      && tx_st == asp_pkg::TX_IDLE) |=> tx_st == asp_pkg::TX_IDLE)
    else $error("sent without clear to send");
  a_pause_on_xoff: assert property ((sw_flow_en && rx_frame_done && rx_ctl_char
      && rx_byte == xoff_char) |=> tx_paused ##1 (tx_st == asp_pkg::TX_IDLE || $past(tx_st) != asp_pkg::TX_IDLE))
    else $error("pause character ignored");
endmodule // asp_port

module asp_top (
  input wire logic clock, // Serial reference clock
  input wire logic rstn, // Sync reset, active low
  input wire logic [asp_pkg::NUM_PORTS-1:0][asp_pkg::DIV_W-1:0] baud_int, // Integer divisors
  input wire logic [asp_pkg::NUM_PORTS-1:0][asp_pkg::FRAC_W-1:0] baud_frac, // Fractions
  input wire logic [asp_pkg::NUM_PORTS-1:0] fast_mode, // 8x oversampling
  input wire logic [asp_pkg::NUM_PORTS-1:0][1:0] data_bits, // Data bits minus five
  input wire logic [asp_pkg::NUM_PORTS-1:0] parity_en, // Parity present
  input wire logic [asp_pkg::NUM_PORTS-1:0][1:0] parity_mode, // Parity kind
  input wire logic [asp_pkg::NUM_PORTS-1:0] stop2, // Two stop bits
  input wire logic [asp_pkg::NUM_PORTS-1:0] fifo_en, // FIFOs enabled
  input wire logic [asp_pkg::NUM_PORTS-1:0] send_break, // Drive break
  input wire logic [asp_pkg::NUM_PORTS-1:0] cts_flow_en, // CTS gating
  input wire logic [asp_pkg::NUM_PORTS-1:0] sw_flow_en, // In-band flow control
  input wire logic [asp_pkg::NUM_PORTS-1:0][7:0] xoff_char, // Pause characters
  input wire logic [asp_pkg::NUM_PORTS-1:0][7:0] xon_char, // Resume characters
  input wire logic dtr_req, // Port zero terminal ready
  input wire logic [asp_pkg::NUM_PORTS-1:0][7:0] tx_data, // Bytes to send
  input wire logic [asp_pkg::NUM_PORTS-1:0] tx_valid, // Bytes offered
  output logic [asp_pkg::NUM_PORTS-1:0] tx_ready, // Bytes accepted
  output logic [asp_pkg::NUM_PORTS-1:0][asp_pkg::RX_W-1:0] rx_data, // Entries
  output logic [asp_pkg::NUM_PORTS-1:0] rx_valid, // Entries available
  input wire logic [asp_pkg::NUM_PORTS-1:0] rx_ready, // Entries consumed
  input wire logic [asp_pkg::NUM_PORTS-1:0] serial_rx_pin, // Receive lines
  output logic [asp_pkg::NUM_PORTS-1:0] serial_tx_pin, // Transmit lines
  input wire logic [asp_pkg::NUM_PORTS-1:0] cts_n_pin, // Clear to send, low
  output logic [asp_pkg::NUM_PORTS-1:0] rts_n_pin, // Request to send, low
  input wire logic dcd_n_pin, // Port zero carrier detect, low
  input wire logic dsr_n_pin, // Port zero data set ready, low
  input wire logic ri_n_pin, // Port zero ring indicator, low
  output logic dtr_n_pin, // Port zero terminal ready, low
  output logic [asp_pkg::NUM_PORTS-1:0][3:0] modem_status, // Modem levels
  output logic [asp_pkg::NUM_PORTS-1:0] tx_paused // Paused by character
);
  logic [asp_pkg::NUM_PORTS-1:0] dtr_n_all;
  assign dtr_n_pin = dtr_n_all[0];

  for (genvar i = 0; i < asp_pkg::NUM_PORTS; i++) begin : g_port
    asp_port #(.HAS_MODEM(i == 0)) u_port (
      .clock(clock), .rstn(rstn),
      .baud_int(baud_int[i]), .baud_frac(baud_frac[i]), .fast_mode(fast_mode[i]),
      .data_bits(data_bits[i]), .parity_en(parity_en[i]), .parity_mode(parity_mode[i]),
      .stop2(stop2[i]), .fifo_en(fifo_en[i]), .send_break(send_break[i]),
      .cts_flow_en(cts_flow_en[i]), .sw_flow_en(sw_flow_en[i]),
      .xoff_char(xoff_char[i]), .xon_char(xon_char[i]), .dtr_req(dtr_req),
      .tx_data(tx_data[i]), .tx_valid(tx_valid[i]), .tx_ready(tx_ready[i]),
      .rx_data(rx_data[i]), .rx_valid(rx_valid[i]), .rx_ready(rx_ready[i]),
      .serial_rx_pin(serial_rx_pin[i]), .serial_tx_pin(serial_tx_pin[i]),
      .cts_n_pin(cts_n_pin[i]), .rts_n_pin(rts_n_pin[i]),
      .dcd_n_pin(dcd_n_pin), .dsr_n_pin(dsr_n_pin), .ri_n_pin(ri_n_pin),
      .dtr_n_pin(dtr_n_all[i]), .modem_status(modem_status[i]), .tx_paused(tx_paused[i])
    );
  end
endmodule // asp_top

// ===== tb/asp_peer.sv
`timescale 1ns/1ns
module asp_peer (
  input wire logic clock, // Bench clock
  input wire logic line_in, // From device transmit pin
  output logic line_out // To device receive pin
);
  // Line driven high by this model between frames
  initial line_out = 1'b1;
  bit stuck = 1'b0;
  // Raw bits LSB first, caller builds start, parity and stops
  task automatic send(input logic [11:0] bits, input int n, input int len);
    for (int i = 0; i < n; i++) begin
      line_out <= bits[i];
      repeat (len) @(posedge clock);
    end
    line_out <= 1'b1;
    // Idle edge so a following frame never writes the line twice in one step
    @(posedge clock);
  endtask
  // Mid-bit sampling after the start edge; gives up after a bounded wait
  task automatic grab(output logic [11:0] bits, input int n, input int len);
    int t;
    bits = 12'h000;
    t = 0;
    while (line_in !== 1'b0 && t < 4000) begin
      @(posedge clock);
      t++;
    end
    if (t >= 4000) stuck = 1'b1;
    repeat (len / 2) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      bits[i] = line_in;
      repeat (len) @(posedge clock);
    end
  endtask
endmodule // asp_peer

// ===== tb/async_serial_port_bench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module async_serial_port_bench;
  logic clock, rstn, dtr_req, dcd_n_pin, dsr_n_pin, ri_n_pin, dtr_n_pin, peer_line;
  logic [2:0][15:0] baud_int;
  logic [2:0][5:0] baud_frac;
  logic [2:0][1:0] data_bits, parity_mode;
  logic [2:0][7:0] xoff_char, xon_char, tx_data;
  logic [2:0][11:0] rx_data;
  logic [2:0][3:0] modem_status;
  logic [2:0] fast_mode, parity_en, stop2, fifo_en, send_break, cts_flow_en, sw_flow_en;
  logic [2:0] tx_valid, tx_ready, rx_valid, rx_ready, serial_rx_pin, serial_tx_pin;
  logic [2:0] cts_n_pin, rts_n_pin, tx_paused;
  int error_cnt, checked;
  // Ports one and two face each other
  assign serial_rx_pin = {serial_tx_pin[1], serial_tx_pin[2], peer_line};
  asp_top dut (.clock, .rstn, .baud_int, .baud_frac, .fast_mode, .data_bits, .parity_en,
    .parity_mode, .stop2, .fifo_en, .send_break, .cts_flow_en, .sw_flow_en, .xoff_char,
    .xon_char, .dtr_req, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready,
    .serial_rx_pin, .serial_tx_pin, .cts_n_pin, .rts_n_pin, .dcd_n_pin, .dsr_n_pin,
    .ri_n_pin, .dtr_n_pin, .modem_status, .tx_paused);
  asp_peer peer (.clock(clock), .line_in(serial_tx_pin[0]), .line_out(peer_line));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [11:0] frame(input logic [7:0] d, input int nb, input bit pe,
      input logic [1:0] pm, input bit s2, output int n);
    logic [11:0] f;
    f = 12'hFFF;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) f[1 + i] = d[i];
    n = 1 + nb;
    if (pe) begin
      f[n] = pm[1] ? pm[0] : (^d ^ pm[0]);
      n++;
    end
    n = n + 1 + s2;
    return f;
  endfunction
  task automatic push(input int p, input logic [7:0] d);
    int i;
    tx_data[p] <= d;
    tx_valid[p] <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (tx_ready[p] !== 1'b1 && i < 4000);
    tx_valid[p] <= 1'b0;
    if (i >= 4000) begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic pop(input int p, input logic [11:0] exp);
    int i;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (rx_valid[p] !== 1'b1 && i < 8000);
    if (i >= 8000) begin
      error_cnt++;
      end_sim();
    end
    `CHK(rx_data[p], exp)
    rx_ready[p] <= 1'b1;
    @(posedge clock);
    rx_ready[p] <= 1'b0;
  endtask
  task automatic grab_frame(output logic [11:0] got, input int n, input int len);
    peer.grab(got, n, len);
    if (peer.stuck) begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic fill(output int n);
    n = 0;
    // Let the clear-to-send level pass its synchroniser before offering data
    repeat (3) @(posedge clock);
    tx_data[0] <= 8'h42;
    tx_valid[0] <= 1'b1;
    repeat (80) begin
      @(posedge clock);
      if (tx_ready[0] === 1'b1) n++;
    end
    tx_valid[0] <= 1'b0;
  endtask
  task automatic t_format();
    logic [11:0] f, got;
    logic [7:0] d;
    int n, nb, len;
    for (int m = 0; m < 6; m++) begin
      nb = 5 + m % 4;
      len = (m < 4) ? 8 : (m == 4) ? 16 : 40;
      d = (8'hA5 ^ 8'(m)) & ~(8'hFF << nb);
      f = frame(d, nb, m < 4, 2'(m), m % 2, n);
      @(posedge clock);
      data_bits[0] <= 2'(m);
      parity_mode[0] <= 2'(m);
      parity_en[0] <= (m < 4);
      stop2[0] <= m % 2;
      fast_mode[0] <= (m < 4);
      // Divisor 2.5: ticks alternate 2 and 3 clocks, 40 clocks per 16x bit
      baud_int[0] <= (m == 5) ? 16'h0002 : 16'h0001;
      baud_frac[0] <= (m == 5) ? 6'h20 : 6'h00;
      push(0, d);
      grab_frame(got, n, len);
      `CHK(got, f & ~(12'hFFF << n))
      peer.send(f, n, len);
      pop(0, {4'h0, d});
    end
    baud_int[0] <= 16'h0001;
    baud_frac[0] <= 6'h00;
    stop2[0] <= 1'b0;
    $display("t_format done");
  endtask
  task automatic t_errors();
    logic [11:0] f;
    int n;
    @(posedge clock);
    parity_en[0] <= 1'b1;
    parity_mode[0] <= asp_pkg::PAR_EVEN;
    data_bits[0] <= 2'h3;
    fast_mode[0] <= 1'b1;
    peer.send(12'h000, 1, 2);
    repeat (200) @(posedge clock);
    `CHK(rx_valid[0], 1'b0)
    f = frame(8'h5A, 8, 1, 2'h0, 0, n);
    peer.send(f ^ 12'h200, n, 8);
    pop(0, 12'h25A);
    peer.send(f & 12'hBFF, n, 8);
    pop(0, 12'h15A);
    peer.send(12'h000, 12, 16);
    pop(0, 12'h500);
    $display("t_errors done");
  endtask
  task automatic t_flow();
    logic [11:0] f, got;
    int n;
    logic low;
    @(posedge clock);
    sw_flow_en[0] <= 1'b1;
    parity_en[0] <= 1'b0;
    f = frame(8'h13, 8, 0, 2'h0, 0, n);
    peer.send(f, n, 8);
    for (int i = 0; i < 100 && tx_paused[0] !== 1'b1; i++) @(posedge clock);
    `CHK(tx_paused[0], 1'b1)
    push(0, 8'h77);
    low = 1'b0;
    repeat (300) begin
      @(posedge clock);
      low = low | !serial_tx_pin[0];
    end
    `CHK(low, 1'b0)
    `CHK(rx_valid[0], 1'b0)
    f = frame(8'h11, 8, 0, 2'h0, 0, n);
    peer.send(f, n, 8);
    grab_frame(got, 10, 8);
    `CHK(got[9:0], {1'b1, 8'h77, 1'b0})
    `CHK(tx_paused[0], 1'b0)
    sw_flow_en[0] <= 1'b0;
    $display("t_flow done");
  endtask
  task automatic t_pins();
    @(posedge clock);
    cts_n_pin <= 3'b010;
    dcd_n_pin <= 1'b0;
    ri_n_pin <= 1'b0;
    dtr_req <= 1'b1;
    send_break[0] <= 1'b1;
    repeat (2) @(posedge clock);
    `CHK(serial_tx_pin[0], 1'b0)
    repeat (3) @(posedge clock);
    `CHK(modem_status, {4'h8, 4'h0, 4'hD})
    `CHK(dtr_n_pin, 1'b0)
    send_break[0] <= 1'b0;
    cts_n_pin <= 3'b000;
    push(1, 8'h3C);
    pop(2, 12'h03C);
    $display("t_pins done");
  endtask
  task automatic t_buffer();
    logic [11:0] f, got;
    int n, k;
    @(posedge clock);
    fifo_en[0] <= 1'b0;
    cts_flow_en[0] <= 1'b1;
    cts_n_pin[0] <= 1'b1;
    fill(k);
    `CHK(k, 1)
    cts_n_pin[0] <= 1'b0;
    grab_frame(got, 10, 8);
    `CHK(got[9:0], {1'b1, 8'h42, 1'b0})
    fifo_en[0] <= 1'b1;
    cts_n_pin[0] <= 1'b1;
    fill(k);
    `CHK(k, 64)
    for (int i = 0; i < 66; i++) begin
      f = frame(8'(i), 8, 0, 2'h0, 0, n);
      peer.send(f, n, 8);
    end
    `CHK(rts_n_pin[0], 1'b1)
    for (int i = 0; i < 64; i++) pop(0, {4'h0, 8'(i)});
    `CHK(rts_n_pin[0], 1'b0)
    f = frame(8'hC3, 8, 0, 2'h0, 0, n);
    peer.send(f, n, 8);
    pop(0, 12'h8C3);
    $display("t_buffer done");
  endtask
  initial begin
    error_cnt = 0;
    checked = 0;
    rstn = 1'b0;
    baud_int = {3{16'h0001}};
    baud_frac = '0;
    fast_mode = 3'b001;
    data_bits = {3{2'h3}};
    parity_en = 3'b000;
    parity_mode = '0;
    stop2 = 3'b000;
    fifo_en = 3'b111;
    send_break = 3'b000;
    cts_flow_en = 3'b000;
    sw_flow_en = 3'b000;
    xoff_char = {3{8'h13}};
    xon_char = {3{8'h11}};
    tx_data = '0;
    tx_valid = 3'b000;
    rx_ready = 3'b000;
    cts_n_pin = 3'b000;
    {dcd_n_pin, dsr_n_pin, ri_n_pin, dtr_req} = 4'hE;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    t_format();
    t_errors();
    t_flow();
    t_pins();
    t_buffer();
    end_sim();
  end
endmodule // async_serial_port_bench
